// ==== inc/bsr_pkg.sv ====
// constants shared by the scan test register block
package bsr_pkg;
  // register lengths
  localparam int BSR_LEN = 196;
  localparam int ID_LEN = 32;
  // instruction codes
  localparam logic [2:0] INS_SAMPLE = 3'h2;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_CLAMP = 3'h3;
  localparam logic [2:0] INS_HIGHZ = 3'h4;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  // identification code fields; values are arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h5a5a;
  localparam logic [10:0] ID_MAKER = 11'h2aa;
  // boundary cell positions
  localparam int CELL_GLOBAL_OE = 0;
  localparam int CELL_IRQ_DRIVE = 2;
  localparam int CELL_IRQ_OUT = 3;
  localparam int CELL_IRQ_IN = 4;
  localparam int CELL_FS_DIR = 24;
  localparam int CELL_FS_OUT = 25;
  localparam int CELL_FS_IN = 26;
  localparam int CELL_TRIB_BASE = 36;
  // synchroniser depth for pins
  localparam int SYNC_STAGES = 3;
endpackage

// ==== inc/bsr_sync_if.sv ====
// filtered pin levels passed from the synchroniser to the registers
`timescale 1ns/10ps
interface bsr_sync_if #(
  parameter int W = 2
);
  logic [W-1:0] lvl; // agreed level of each pin
  modport src (output lvl);
  modport dst (input lvl);
endinterface

// ==== logic/bsr_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module bsr_pin_sync #(
  parameter int W = 2
) (
  input wire logic clk_in, // block clock
  input wire logic rst_in, // async reset, high
  input wire logic [W-1:0] pin_in, // raw pins
  bsr_sync_if.src sync_out // agreed levels
);
  logic [W-1:0] s1_ff; // first stage, read by s2 only
  logic [W-1:0] s2_ff; // second stage
  logic [W-1:0] s3_ff; // third stage
  logic [W-1:0] lvl_ff; // agreed level
  wire [W-1:0] agree = ~(s2_ff ^ s3_ff); // stages two and three equal
  wire [W-1:0] nxt_lvl = (agree & s3_ff) | (~agree & lvl_ff);

  //////////////////////////////////////////////////////////////////////
  // shift chain and filtered level
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign sync_out.lvl = lvl_ff;
endmodule

// ==== logic/bsr_test_regs.sv ====
// bypass, identification and boundary scan test data registers
`timescale 1ns/10ps
// Operation
// - bypass, boundary and identification registers, all always present
// - one-bit bypass for bypass, clamp, highz
// - identification: 32-bit shift plus 32-bit latch
// - identification selected by idcode or reset state
// - boundary register 196 cells, shift plus latch
// - cell 0 high tri-states all outputs in extest and clamp
// - cell 24 sets frame-start direction
// - fixed cell order, tributaries four cells each
// - id code lsb one, loaded at capture
// - latches copy shift stages at update fall
// - shift one stage per rising scan edge
module bsr_test_regs #(
  parameter int BSR_LEN = bsr_pkg::BSR_LEN, // boundary length
  parameter int ID_LEN = bsr_pkg::ID_LEN // identification length
) (
  input wire logic clk_in, // 200 mhz block clock
  input wire logic rst_in, // async reset, high
  input wire logic scan_clock_in, // test clock pin
  input wire logic scan_serial_in, // test serial data pin
  input wire logic [2:0] instr_in, // current instruction
  input wire logic tlr_in, // controller in test-logic-reset
  input wire logic capture_dr_in, // controller in capture-dr
  input wire logic shift_dr_in, // controller in shift-dr
  input wire logic update_dr_in, // controller in update-dr
  input wire logic [BSR_LEN-1:0] pin_level_in, // pin levels per cell
  output logic scan_serial_out, // test serial data out
  output logic scan_serial_oe_out, // serial out enable
  output logic [BSR_LEN-1:0] cell_latch_out, // boundary latches
  output logic [ID_LEN-1:0] id_latch_out, // identification latch
  output logic test_drive_out, // pins driven from latches
  output logic pins_hiz_out, // all outputs tri-stated
  output logic irq_pin_out, // open-drain irq level
  output logic irq_pin_oe_out, // irq pin pulled low
  output logic tx_frame_start_pin_out, // frame-start pin level
  output logic tx_frame_start_pin_oe_out // frame-start pin driven
);
  localparam int SW = BSR_LEN + 2; // synced width: pins, clock, data
  localparam logic [31:0] ID_CODE =
    {bsr_pkg::ID_VERSION, bsr_pkg::ID_PART, bsr_pkg::ID_MAKER, 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // synchronised pins
  bsr_sync_if #(.W(SW)) sync_bus (); // agreed pin levels
  bsr_pin_sync #(.W(SW)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    // test clock enters inverted so cleared stages match its high idle
    .pin_in ({pin_level_in, scan_serial_in, ~scan_clock_in}),
    .sync_out (sync_bus.src)
  );

  wire sclk = ~sync_bus.lvl[0]; // filtered test clock, true sense
  wire sdi = sync_bus.lvl[1]; // filtered serial in
  wire [BSR_LEN-1:0] pins = sync_bus.lvl[SW-1:2]; // filtered pins

  logic sclk_prev_ff; // test clock one cycle ago
  wire rise = sclk & ~sclk_prev_ff; // rising test clock edge
  wire fall = ~sclk & sclk_prev_ff; // falling test clock edge

  ////////////////////////////////////////////////////////////////////////
  // register selection
  // identification on idcode or reset state
  wire id_sel = tlr_in | (instr_in == bsr_pkg::INS_IDCODE);
  // bypass for bypass, clamp and highz
  wire byp_sel = ~tlr_in & ((instr_in == bsr_pkg::INS_BYPASS) |
    (instr_in == bsr_pkg::INS_CLAMP) | (instr_in == bsr_pkg::INS_HIGHZ));
  wire bsr_sel = ~tlr_in & ((instr_in == bsr_pkg::INS_EXTEST) |
    (instr_in == bsr_pkg::INS_SAMPLE));
  wire is_extest = ~tlr_in & (instr_in == bsr_pkg::INS_EXTEST);
  wire is_clamp = ~tlr_in & (instr_in == bsr_pkg::INS_CLAMP);
  wire is_highz = ~tlr_in & (instr_in == bsr_pkg::INS_HIGHZ);

  logic bypass_ff; // one-bit bypass stage
  logic [ID_LEN-1:0] id_sr_ff; // identification shift stages
  logic [ID_LEN-1:0] id_latch_ff; // identification latch
  logic [BSR_LEN-1:0] bsr_sr_ff; // boundary shift stages
  logic [BSR_LEN-1:0] bsr_latch_ff; // boundary latches
  logic sdo_ff; // serial out flop
  logic sdo_oe_ff; // serial out enable flop

  // next serial bit from the selected register
  wire sel_lsb = id_sel ? id_sr_ff[0] : (bsr_sel ? bsr_sr_ff[0] : bypass_ff);
  wire do_cap = rise & capture_dr_in; // capture edge
  wire do_shift = rise & shift_dr_in; // shift edge
  wire do_upd = fall & update_dr_in; // update edge

  ////////////////////////////////////////////////////////////////////////
  // clock edge tracking
  always_ff @(posedge clk_in or posedge rst_in) begin
    // high matches idle clock, so no false edge after reset
    if (rst_in) sclk_prev_ff <= 1'b1;
    else sclk_prev_ff <= sclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // bypass stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bypass_ff <= 1'b0;
    end else if (byp_sel & do_cap) begin
      bypass_ff <= 1'b0;
    end else if (byp_sel & do_shift) begin
      bypass_ff <= sdi;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // identification shift stages
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      id_sr_ff <= '0;
    end else if (id_sel & do_cap) begin
      id_sr_ff <= ID_CODE[ID_LEN-1:0];
    end else if (id_sel & do_shift) begin
      id_sr_ff <= {sdi, id_sr_ff[ID_LEN-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boundary shift stages
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bsr_sr_ff <= '0;
    end else if (bsr_sel & do_cap) begin
      // cells sampled in fixed pin order
      bsr_sr_ff <= pins;
    end else if (bsr_sel & do_shift) begin
      bsr_sr_ff <= {sdi, bsr_sr_ff[BSR_LEN-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parallel latches, copied only on update falling edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      id_latch_ff <= '0;
      bsr_latch_ff <= '0;
    end else if (do_upd) begin
      if (id_sel) id_latch_ff <= id_sr_ff;
      if (bsr_sel) bsr_latch_ff <= bsr_sr_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial out changes on falling test clock
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else if (fall) begin
      sdo_ff <= sel_lsb;
      sdo_oe_ff <= shift_dr_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin control from latched cells
  wire drive = is_extest | is_clamp; // pins follow latches
  wire cell_hiz = bsr_latch_ff[bsr_pkg::CELL_GLOBAL_OE]; // cell 0 level
  // cell 0 tri-states outputs while driving
  wire glob_hiz = is_highz | (drive & cell_hiz);
  // cell 24 low makes frame-start an output
  wire fs_oe = drive & ~glob_hiz & ~bsr_latch_ff[bsr_pkg::CELL_FS_DIR];
  wire irq_oe = drive & ~glob_hiz & ~bsr_latch_ff[bsr_pkg::CELL_IRQ_DRIVE];

  assign scan_serial_out = sdo_ff;
  assign scan_serial_oe_out = sdo_oe_ff;
  assign cell_latch_out = bsr_latch_ff;
  assign id_latch_out = id_latch_ff;
  assign test_drive_out = drive;
  assign pins_hiz_out = glob_hiz;
  assign irq_pin_out = 1'b0;
  assign irq_pin_oe_out = irq_oe;
  assign tx_frame_start_pin_out = bsr_latch_ff[bsr_pkg::CELL_FS_OUT];
  assign tx_frame_start_pin_oe_out = fs_oe;

  ////////////////////////////////////////////////////////////////////////
  // checks
  byp_capture_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (byp_sel & do_cap) |=> (bypass_ff == 1'b0))
    else $error("bypass did not capture zero");

  byp_shift_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (byp_sel & do_shift) |=> (bypass_ff == $past(sdi)))
    else $error("bypass stage did not take serial in");

  id_load_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (id_sel & do_cap) |=> (id_sr_ff == ID_CODE) && id_sr_ff[0])
    else $error("identification code not loaded");

  id_select_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (tlr_in & fall) |=> (scan_serial_out == $past(id_sr_ff[0])))
    else $error("identification not selected in reset state");

  bsr_shift_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (bsr_sel & do_shift) |=>
      (bsr_sr_ff[BSR_LEN-2:0] == $past(bsr_sr_ff[BSR_LEN-1:1])))
    else $error("boundary register did not shift one stage");

  latch_hold_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !do_upd |=> ($stable(bsr_latch_ff) && $stable(id_latch_ff)))
    else $error("latch changed outside update");

  id_update_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (id_sel & do_upd) |=> (id_latch_ff == $past(id_sr_ff)))
    else $error("identification latch not updated");

  global_hiz_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (drive & bsr_latch_ff[bsr_pkg::CELL_GLOBAL_OE]) |->
      (pins_hiz_out && !fs_oe && !irq_oe))
    else $error("cell zero did not tri-state outputs");

  frame_dir_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (drive & !glob_hiz & !bsr_latch_ff[bsr_pkg::CELL_FS_DIR]) |->
      (tx_frame_start_pin_oe_out &&
      tx_frame_start_pin_out == bsr_latch_ff[bsr_pkg::CELL_FS_OUT]))
    else $error("frame-start direction wrong");

  capture_pins_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (bsr_sel & do_cap) |=> (bsr_sr_ff == $past(pins)))
    else $error("boundary capture order wrong");
endmodule

// ==== test/bsr_scan_tester.sv ====
// scan tester model: drives the test clock and serial data
`timescale 1ns/10ps
module bsr_scan_tester (
  input wire logic clk_in, // bench clock
  input wire logic sdo_in, // serial out of the block
  output logic tck_out, // test clock, idles high between frames
  output logic sdi_out // serial data into the block
);
  // idle levels before the first frame
  initial begin
    tck_out = 1'b1;
    sdi_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one stage per clock, 80 ns low then 80 ns high
  task automatic bit_cycle(input logic d, output logic q);
    @(posedge clk_in);
    sdi_out <= d;
    tck_out <= 1'b0;
    repeat (16) @(posedge clk_in);
    q = sdo_in; // settled well after the fall
    tck_out <= 1'b1;
    repeat (16) @(posedge clk_in);
    sdi_out <= ~d; // stale data turned over once hold is over
  endtask
endmodule

// ==== test/bsr_test_regs_bench.sv ====
// self-checking bench for the scan test registers
`timescale 1ns/10ps
module bsr_test_regs_bench;
  localparam int N = bsr_pkg::BSR_LEN; // boundary length
  logic clk_in, rst_in; // clock and reset
  logic tck, sdi, sdo, sdo_oe, tlr, cap, sft, upd; // scan side
  logic drv, hiz, irq, irq_oe, fs, fs_oe; // pin controls
  logic [2:0] instr; // current instruction
  logic [N-1:0] pins, latch; // pin levels and latches
  logic [31:0] idl; // id latch
  int error_cnt = 0; // mismatches
  int checks = 0; // comparisons
  int cyc = 0; // timeout count
  bsr_test_regs uut (.clk_in(clk_in), .rst_in(rst_in),
    .scan_clock_in(tck), .scan_serial_in(sdi), .instr_in(instr),
    .tlr_in(tlr), .capture_dr_in(cap), .shift_dr_in(sft),
    .update_dr_in(upd), .pin_level_in(pins), .scan_serial_out(sdo),
    .scan_serial_oe_out(sdo_oe), .cell_latch_out(latch),
    .id_latch_out(idl), .test_drive_out(drv), .pins_hiz_out(hiz),
    .irq_pin_out(irq), .irq_pin_oe_out(irq_oe),
    .tx_frame_start_pin_out(fs), .tx_frame_start_pin_oe_out(fs_oe));
  bsr_scan_tester tst (.clk_in(clk_in), .sdo_in(sdo), .tck_out(tck),
    .sdi_out(sdi));
  ////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk(input string nm, input logic [N-1:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // controller state levels
  task automatic st(input logic c, s, u);
    @(posedge clk_in);
    cap <= c;
    sft <= s;
    upd <= u;
  endtask
  // capture, n shifts lsb first, update
  task automatic dr_scan(input int n, input logic [N-1:0] din,
                         output logic [N-1:0] dout);
    logic q;
    logic [N-1:0] keep;
    dout = '0;
    keep = latch;
    st(1'b1, 1'b0, 1'b0);
    tst.bit_cycle(1'b0, q);
    st(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      tst.bit_cycle(din[i], q);
      dout[i] = q;
    end
    chk("serial oe", 1'b1, sdo_oe);
    chk("latch hold", keep, latch);
    st(1'b0, 1'b0, 1'b1);
    tst.bit_cycle(1'b0, q);
    st(1'b0, 1'b0, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // identification code out and latch
  task automatic t_id(input logic t, input logic [2:0] ins);
    logic [N-1:0] o;
    logic [N-1:0] d;
    d = 196'h0c3a96e1;
    @(posedge clk_in);
    tlr <= t;
    instr <= ins;
    dr_scan(32, d, o);
    chk("id code", {bsr_pkg::ID_VERSION, bsr_pkg::ID_PART,
        bsr_pkg::ID_MAKER, 1'b1}, o[31:0]);
    if (!t) chk("id latch", d[31:0], idl);
  endtask
  // one-stage bypass path, zero captured
  task automatic t_byp(input logic [2:0] ins);
    logic [N-1:0] o;
    @(posedge clk_in);
    instr <= ins;
    dr_scan(4, 196'hd, o);
    chk("bypass out", 196'ha, o);
    chk("highz", ins == bsr_pkg::INS_HIGHZ, hiz);
    chk("clamp drive", ins == bsr_pkg::INS_CLAMP, drv);
  endtask
  // boundary capture, latch and control cells
  task automatic t_bsr;
    logic [N-1:0] d, o;
    logic [2:0] c; // cells 0, 2, 24 for this pass
    for (int k = 0; k < 3; k++) begin
      c = 3'h1 << k;
      d = {49{4'ha}};
      d[0] = c[0];
      d[2] = c[1];
      d[24] = c[2];
      d[25] = c[1];
      @(posedge clk_in);
      instr <= (k == 0) ? bsr_pkg::INS_SAMPLE : bsr_pkg::INS_EXTEST;
      // one marked tributary cell per pass, the other three low
      pins <= ({49{4'h6}} & ~(196'hf << bsr_pkg::CELL_TRIB_BASE)) |
        (196'h1 << (bsr_pkg::CELL_TRIB_BASE + k));
      dr_scan(N, d, o);
      chk("capture", pins, o);
      chk("trib cells", 4'h1 << k, o[bsr_pkg::CELL_TRIB_BASE +: 4]);
      chk("cell latch", d, latch);
      @(posedge clk_in);
      instr <= bsr_pkg::INS_EXTEST;
      @(posedge clk_in);
      chk("drive", 1'b1, drv);
      chk("hiz", c[0], hiz);
      chk("irq oe", !c[0] && !c[1], irq_oe);
      chk("fs oe", !c[0] && !c[2], fs_oe);
      chk("fs level", c[1], fs);
      chk("irq level", 1'b0, irq);
      // clamp drives from the same latches, cell 0 still applies
      instr <= bsr_pkg::INS_CLAMP;
      @(posedge clk_in);
      chk("clamp hiz", c[0], hiz);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // 200 mhz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  // main sequence
  initial begin
    rst_in = 1'b1;
    instr = bsr_pkg::INS_BYPASS;
    tlr = 1'b0;
    cap = 1'b0;
    sft = 1'b0;
    upd = 1'b0;
    pins = {49{4'h6}};
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_id(1'b1, bsr_pkg::INS_BYPASS);
    t_id(1'b0, bsr_pkg::INS_IDCODE);
    t_byp(bsr_pkg::INS_BYPASS);
    t_byp(bsr_pkg::INS_CLAMP);
    t_byp(bsr_pkg::INS_HIGHZ);
    t_bsr();
    close_out();
  end
endmodule
